// ===== ide_timing_consts.svh
// constants for the ide cycle timing select block
// What this block does
// - upper code bits pick clock, lower speed
// - 16-bit basic cycle: setup, command, recovery counts
// - 8-bit basic command, recovery counts depend on clock only
// - track drive-select bit, switch active timing
// - mode 0: basic table or timing bank 0
// - mode 1: timing bank 1 or bank 0
// - select bits 2 and 3 serve drives 0, 1
// - hidden registers reachable only after unlock
// - relock after programming; then only tracking
// - range bit picks primary or secondary ports
// - strobe is pulse plus one, gap recovery plus two
// - head/drive bit 0 picks bank being loaded
// - basic path strobes last table command count
`ifndef IDE_TIMING_CONSTS_SVH
`define IDE_TIMING_CONSTS_SVH
`define PRI_BASE        10'h1f0
`define SEC_BASE        10'h170
`define OFS_DATA_RD     3'h0
`define OFS_DATA_WR     3'h1
`define OFS_UNLOCK      3'h2
`define OFS_TSEL        3'h3
`define OFS_HEAD        3'h6
`define OFS_RELOCK      3'h7
`define HEAD_DRIVE_BIT  4
`define HEAD_BANK_BIT   0
`define TSEL_MODE_BIT   7
`define TSEL_DRV0_BIT   2
`define TSEL_DRV1_BIT   3
`define TSEL_RESET      8'h00
`define BANK_RESET      8'h00
`define UNLOCK_VALUE    8'h5a
`define UNLOCK_WRITES   2
`define PULSE_ADD       5'd1
`define RECOV_ADD       5'd2
`define ENH_SETUP       5'd1
`endif

// ===== ide_timing_pkg.sv
// types for the ide cycle timing select block
package ide_timing_pkg;
    typedef struct packed {
        logic [4:0] setup;
        logic [4:0] cmd;
        logic [4:0] rec;
    } timing_t;
    typedef struct packed {
        logic       wr;
        logic [9:0] addr;
        logic [7:0] data;
    } io_write_t;
    typedef struct packed {
        logic [7:0] rd;
        logic [7:0] wr;
    } bank_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_CMD,
        ST_RECOV
    } cycle_state_t;
endpackage

// ===== ide_unlock_detect.sv
// unlock detector for the hidden timing registers
`timescale 1ns/100ps
`include "ide_timing_consts.svh"
module ide_unlock_detect #(
    parameter logic [7:0] UNLOCK_VALUE  = `UNLOCK_VALUE,
    parameter int         UNLOCK_WRITES = `UNLOCK_WRITES
) (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       hit_i,
    input  wire logic [2:0] offset_i,
    input  wire logic [7:0] data_i,
    output logic            unlocked_o
);
    logic [3:0] match_cnt_reg;
    logic       unlocked_reg;
    logic       key_hit;

    assign key_hit    = hit_i && offset_i == `OFS_UNLOCK
                        && data_i == UNLOCK_VALUE;
    assign unlocked_o = unlocked_reg;

    // any other access in the range breaks the key sequence
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            match_cnt_reg <= 4'h0;
        end else if (hit_i) begin
            match_cnt_reg <= key_hit ? match_cnt_reg + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            unlocked_reg <= 1'b0;
        end else if (hit_i && offset_i == `OFS_RELOCK) begin
            unlocked_reg <= 1'b0;
        end else if (key_hit
                     && match_cnt_reg == 4'(UNLOCK_WRITES - 1)) begin
            unlocked_reg <= 1'b1;
        end
    end

    property p_relock;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        hit_i && offset_i == `OFS_RELOCK |=> !unlocked_o;
    endproperty
    a_relock: assert property (p_relock)
        else $error("registers stayed visible after relock");
endmodule

// ===== ide_cycle_timing_select.sv
// ide cycle timing selection and strobe generation
`timescale 1ns/100ps
`include "ide_timing_consts.svh"
module ide_cycle_timing_select #(
    parameter logic [7:0] UNLOCK_VALUE  = `UNLOCK_VALUE,
    parameter int         UNLOCK_WRITES = `UNLOCK_WRITES
) (
    input  wire logic                      sys_clk_i,
    input  wire logic                      sys_rst_i,
    input  wire ide_timing_pkg::io_write_t host_wr_i,
    input  wire logic [3:0]                basic_timing_i,
    input  wire logic                      port_range_sel_i,
    input  wire logic                      cycle_req_i,
    input  wire logic                      cycle_read_i,
    input  wire logic                      cycle_wide_i,
    output logic                           cycle_busy_o,
    output logic                           cycle_done_o,
    output logic                           drive_read_strobe_n_o,
    output logic                           drive_write_strobe_n_o,
    output logic                           active_drive_o,
    output logic                           hidden_open_o,
    output logic [7:0]                     timing_select_o
);
    ide_timing_pkg::cycle_state_t state_reg;
    ide_timing_pkg::timing_t      cur_reg;
    ide_timing_pkg::timing_t      chosen;
    ide_timing_pkg::bank_t        bank0_reg;
    ide_timing_pkg::bank_t        bank1_reg;
    ide_timing_pkg::bank_t        bank_used;
    logic [7:0]                   tsel_reg;
    logic                         drive_reg;
    logic                         load_bank_reg;
    logic [4:0]                   cnt_reg;
    logic                         rd_n_reg;
    logic                         wr_n_reg;
    logic                         done_reg;
    logic                         hit;
    logic [2:0]                   offset;
    logic                         unlocked;
    logic                         src_bit;
    logic                         start;
    logic [7:0]                   bank_byte;
    logic [4:0]                   low_cnt_reg;
    logic [9:0]                   range_base;

    // ------------------------------------------------------------
    // basic timing table
    // ------------------------------------------------------------
    function automatic ide_timing_pkg::timing_t basic_timing(
        input logic [3:0] code,
        input logic       wide
    );
        ide_timing_pkg::timing_t t;
        t = '0;
        // code[3:2] is the clock group, code[1:0] the speed
        unique case (code)
            4'h0: t = '{5'd4, 5'd9, 5'd17};
            4'h1: t = '{5'd3, 5'd7, 5'd10};
            4'h2: t = '{5'd2, 5'd6, 5'd4};
            4'h3: t = '{5'd2, 5'd5, 5'd2};
            4'h4: t = '{5'd3, 5'd7, 5'd14};
            4'h5: t = '{5'd3, 5'd6, 5'd7};
            4'h6: t = '{5'd2, 5'd5, 5'd3};
            4'h7: t = '{5'd2, 5'd4, 5'd2};
            4'h8: t = '{5'd3, 5'd6, 5'd11};
            4'h9: t = '{5'd2, 5'd5, 5'd6};
            4'ha: t = '{5'd2, 5'd4, 5'd2};
            4'hb: t = '{5'd1, 5'd3, 5'd2};
            4'hc: t = '{5'd2, 5'd5, 5'd8};
            4'hd: t = '{5'd2, 5'd4, 5'd4};
            4'he: t = '{5'd1, 5'd3, 5'd2};
            4'hf: t = '{5'd1, 5'd2, 5'd2};
        endcase
        // 8-bit cycles keep the setup of the entry
        if (!wide) begin
            unique case (code[3:2])
                2'h0: begin t.cmd = 5'd15; t.rec = 5'd14; end
                2'h1: begin t.cmd = 5'd12; t.rec = 5'd11; end
                2'h2: begin t.cmd = 5'd10; t.rec = 5'd9;  end
                2'h3: begin t.cmd = 5'd8;  t.rec = 5'd6;  end
            endcase
        end
        return t;
    endfunction

    // ------------------------------------------------------------
    // port decode and unlock
    // ------------------------------------------------------------
    assign range_base = port_range_sel_i ? `SEC_BASE : `PRI_BASE;
    assign hit        = host_wr_i.wr
                        && host_wr_i.addr[9:3] == range_base[9:3];
    assign offset = host_wr_i.addr[2:0];

    ide_unlock_detect #(
        .UNLOCK_VALUE  (UNLOCK_VALUE),
        .UNLOCK_WRITES (UNLOCK_WRITES)
    ) u_unlock (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .hit_i      (hit),
        .offset_i   (offset),
        .data_i     (host_wr_i.data),
        .unlocked_o (unlocked)
    );

    // ------------------------------------------------------------
    // drive tracking and hidden registers
    // ------------------------------------------------------------
    // the head/drive port is always watched, locked or not
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            drive_reg     <= 1'b0;
            load_bank_reg <= 1'b0;
        end else if (hit && offset == `OFS_HEAD) begin
            drive_reg     <= host_wr_i.data[`HEAD_DRIVE_BIT];
            load_bank_reg <= host_wr_i.data[`HEAD_BANK_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tsel_reg <= `TSEL_RESET;
        end else if (unlocked && hit && offset == `OFS_TSEL) begin
            tsel_reg <= host_wr_i.data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bank0_reg <= '{`BANK_RESET, `BANK_RESET};
            bank1_reg <= '{`BANK_RESET, `BANK_RESET};
        end else if (unlocked && hit) begin
            if (offset == `OFS_DATA_RD) begin
                if (load_bank_reg) bank1_reg.rd <= host_wr_i.data;
                else               bank0_reg.rd <= host_wr_i.data;
            end
            if (offset == `OFS_DATA_WR) begin
                if (load_bank_reg) bank1_reg.wr <= host_wr_i.data;
                else               bank0_reg.wr <= host_wr_i.data;
            end
        end
    end

    // ------------------------------------------------------------
    // timing source choice
    // ------------------------------------------------------------
    // select bit 0 takes the first source of the pair, 1 takes bank 0
    assign src_bit = drive_reg ? tsel_reg[`TSEL_DRV1_BIT]
                               : tsel_reg[`TSEL_DRV0_BIT];
    assign bank_used = src_bit ? bank0_reg : bank1_reg;
    assign bank_byte = cycle_read_i ? bank_used.rd : bank_used.wr;

    always_comb begin
        chosen = basic_timing(basic_timing_i, cycle_wide_i);
        if (src_bit || tsel_reg[`TSEL_MODE_BIT]) begin
            chosen.setup = `ENH_SETUP;
            chosen.cmd   = {1'b0, bank_byte[7:4]} + `PULSE_ADD;
            chosen.rec   = {1'b0, bank_byte[3:0]} + `RECOV_ADD;
        end
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    assign start = cycle_req_i && state_reg == ide_timing_pkg::ST_IDLE;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ide_timing_pkg::ST_IDLE;
            cur_reg   <= '0;
            cnt_reg   <= 5'd0;
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                ide_timing_pkg::ST_IDLE: begin
                    if (cycle_req_i) begin
                        cur_reg   <= chosen;
                        cnt_reg   <= chosen.setup - 5'd1;
                        state_reg <= ide_timing_pkg::ST_SETUP;
                    end
                end
                ide_timing_pkg::ST_SETUP: begin
                    if (cnt_reg == 5'd0) begin
                        cnt_reg   <= cur_reg.cmd - 5'd1;
                        state_reg <= ide_timing_pkg::ST_CMD;
                        rd_n_reg  <= !cycle_read_i;
                        wr_n_reg  <= cycle_read_i;
                    end else begin
                        cnt_reg <= cnt_reg - 5'd1;
                    end
                end
                ide_timing_pkg::ST_CMD: begin
                    if (cnt_reg == 5'd0) begin
                        cnt_reg   <= cur_reg.rec - 5'd1;
                        state_reg <= ide_timing_pkg::ST_RECOV;
                        rd_n_reg  <= 1'b1;
                        wr_n_reg  <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 5'd1;
                    end
                end
                ide_timing_pkg::ST_RECOV: begin
                    if (cnt_reg == 5'd0) begin
                        state_reg <= ide_timing_pkg::ST_IDLE;
                        done_reg  <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 5'd1;
                    end
                end
            endcase
        end
    end

    assign cycle_busy_o           = state_reg != ide_timing_pkg::ST_IDLE;
    assign cycle_done_o           = done_reg;
    assign drive_read_strobe_n_o  = rd_n_reg;
    assign drive_write_strobe_n_o = wr_n_reg;
    assign active_drive_o         = drive_reg;
    assign hidden_open_o          = unlocked;
    assign timing_select_o        = tsel_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || (rd_n_reg && wr_n_reg)) begin
            low_cnt_reg <= 5'd0;
        end else begin
            low_cnt_reg <= low_cnt_reg + 5'd1;
        end
    end

    sequence s_head_write;
        hit && offset == `OFS_HEAD;
    endsequence
    sequence s_enh_start;
        start && (src_bit || tsel_reg[`TSEL_MODE_BIT]);
    endsequence

    property p_drive_track;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        s_head_write |=> drive_reg == $past(host_wr_i.data[4]);
    endproperty
    a_drive_track: assert property (p_drive_track)
        else $error("drive select not tracked");

    property p_other_range;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        host_wr_i.wr && !hit ##1 !$past(hit) |-> $stable(drive_reg);
    endproperty
    a_other_range: assert property (p_other_range)
        else $error("drive changed by inactive range");

    property p_locked;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !unlocked |=> $stable(tsel_reg) && $stable(bank0_reg)
                      && $stable(bank1_reg);
    endproperty
    a_locked: assert property (p_locked)
        else $error("hidden register written while locked");

    property p_bank_load;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        unlocked && hit && offset == `OFS_DATA_RD && load_bank_reg
        |=> bank1_reg.rd == $past(host_wr_i.data) && $stable(bank0_reg);
    endproperty
    a_bank_load: assert property (p_bank_load)
        else $error("wrong timing bank loaded");

    property p_basic_src;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        start && !src_bit && !tsel_reg[7]
        |=> cur_reg == basic_timing($past(basic_timing_i),
                                    $past(cycle_wide_i));
    endproperty
    a_basic_src: assert property (p_basic_src)
        else $error("basic table timing not used");

    property p_enh_src;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        s_enh_start |=> cur_reg.cmd == {1'b0, $past(bank_byte[7:4])} + 5'd1
                     && cur_reg.rec == {1'b0, $past(bank_byte[3:0])} + 5'd2;
    endproperty
    a_enh_src: assert property (p_enh_src)
        else $error("bank timing not applied");

    property p_drive_bit;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        start && tsel_reg[drive_reg ? `TSEL_DRV1_BIT : `TSEL_DRV0_BIT]
        |=> cur_reg.cmd == {1'b0, $past(cycle_read_i ? bank0_reg.rd[7:4]
                                                     : bank0_reg.wr[7:4])}
                           + `PULSE_ADD;
    endproperty
    a_drive_bit: assert property (p_drive_bit)
        else $error("drive select bit did not pick bank 0");

    property p_cmd_width;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(rd_n_reg && wr_n_reg) |-> low_cnt_reg == cur_reg.cmd;
    endproperty
    a_cmd_width: assert property (p_cmd_width)
        else $error("strobe width differs from command count");

    property p_reset_default;
        @(posedge sys_clk_i)
        sys_rst_i |=> tsel_reg == 8'h00 && !unlocked && rd_n_reg;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("reset did not restore basic defaults");
endmodule

// ===== ide_drive_model.sv
// drive side model: watches both strobes and measures each pulse
`timescale 1ns/100ps
module ide_drive_model (
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic rd_strobe_n_i,
    input  wire logic wr_strobe_n_i,
    output int        pulse_width_o,
    output int        pulse_count_o,
    output int        overlap_o
);
    int run;
    // a real drive only sees the strobes; width is counted in bus clocks
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            run <= 0;
            pulse_width_o <= 0;
            pulse_count_o <= 0;
            overlap_o <= 0;
        end else begin
            if (!rd_strobe_n_i && !wr_strobe_n_i) begin
                overlap_o <= overlap_o + 1;
            end
            if (!rd_strobe_n_i || !wr_strobe_n_i) begin
                run <= run + 1;
            end else if (run != 0) begin
                pulse_width_o <= run;
                pulse_count_o <= pulse_count_o + 1;
                run <= 0;
            end
        end
    end
endmodule

// ===== test_ide_cycle_timing_select.sv
// self-checking bench for the ide cycle timing select block
`timescale 1ns/100ps
module test_ide_cycle_timing_select;
    logic                      sys_clk_i = 1'b0;
    logic                      sys_rst_i = 1'b1;
    ide_timing_pkg::io_write_t host_wr_i = '0;
    logic [3:0]                basic_timing_i = 4'h0;
    logic                      port_range_sel_i = 1'b0;
    logic                      cycle_req_i = 1'b0;
    logic                      cycle_read_i = 1'b0;
    logic                      cycle_wide_i = 1'b1;
    logic                      busy, done, rd_n, wr_n, act_drv, open_o;
    logic [7:0]                tsel_o;
    int mismatches = 0, samples_checked = 0, seed = 32'h0bcad266;
    int m_tsel = 0, m_drv = 0, m_open = 0, m_hb = 0, m_ucnt = 0;
    int m_brd[2] = '{0, 0}, m_bwr[2] = '{0, 0}, pw, pc, ov, i, j;
    int t_set[16] = '{4, 3, 2, 2, 3, 3, 2, 2, 3, 2, 2, 1, 2, 2, 1, 1};
    int t_cmd[16] = '{9, 7, 6, 5, 7, 6, 5, 4, 6, 5, 4, 3, 5, 4, 3, 2};
    int t_rec[16] = '{17, 10, 4, 2, 14, 7, 3, 2, 11, 6, 2, 2, 8, 4, 2, 2};
    int t_c8[4] = '{15, 12, 10, 8}, t_r8[4] = '{14, 11, 9, 6};

    always #5 sys_clk_i = ~sys_clk_i;

    ide_cycle_timing_select i_dut (
        .sys_clk_i              (sys_clk_i),
        .sys_rst_i              (sys_rst_i),
        .host_wr_i              (host_wr_i),
        .basic_timing_i         (basic_timing_i),
        .port_range_sel_i       (port_range_sel_i),
        .cycle_req_i            (cycle_req_i),
        .cycle_read_i           (cycle_read_i),
        .cycle_wide_i           (cycle_wide_i),
        .cycle_busy_o           (busy),
        .cycle_done_o           (done),
        .drive_read_strobe_n_o  (rd_n),
        .drive_write_strobe_n_o (wr_n),
        .active_drive_o         (act_drv),
        .hidden_open_o          (open_o),
        .timing_select_o        (tsel_o)
    );

    ide_drive_model i_drive (
        .sys_clk_i     (sys_clk_i),
        .sys_rst_i     (sys_rst_i),
        .rd_strobe_n_i (rd_n),
        .wr_strobe_n_i (wr_n),
        .pulse_width_o (pw),
        .pulse_count_o (pc),
        .overlap_o     (ov)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // host write plus the reference update of the hidden state
    task automatic host_write(input logic [9:0] a, input logic [7:0] d);
        logic [9:0] b;
        b = port_range_sel_i ? 10'h170 : 10'h1f0;
        @(posedge sys_clk_i);
        host_wr_i <= '{wr: 1'b1, addr: a, data: d};
        if (a[9:3] == b[9:3]) begin
            if (a[2:0] == 3'h2 && d == 8'h5a) m_ucnt++;
            else m_ucnt = 0;
            if (m_ucnt >= 2) m_open = 1;
            if (a[2:0] == 3'h6) begin
                m_drv = d[4];
                m_hb = d[0];
            end
            if (a[2:0] == 3'h7) m_open = 0;
            else if (m_open != 0 && a[2:0] == 3'h0) m_brd[m_hb] = d;
            else if (m_open != 0 && a[2:0] == 3'h1) m_bwr[m_hb] = d;
            else if (m_open != 0 && a[2:0] == 3'h3) m_tsel = d;
        end
        @(posedge sys_clk_i);
        host_wr_i.wr <= 1'b0;
        #1;
        check(tsel_o === m_tsel[7:0], "timing select");
        check(act_drv === m_drv[0], "active drive");
        check(open_o === m_open[0], "hidden open");
    endtask

    // one ide cycle, timed against the reference source selection
    task automatic run_cycle(input logic rd, input logic w);
        int s, c, r, f, l, dn, k, byt, idx, oth, pc0;
        logic sb;
        f = 0;
        l = 0;
        dn = 0;
        oth = 0;
        pc0 = pc;
        if (m_tsel[2 + m_drv] == 0 && m_tsel[7] == 0) begin
            s = t_set[basic_timing_i];
            c = w ? t_cmd[basic_timing_i] : t_c8[basic_timing_i[3:2]];
            r = w ? t_rec[basic_timing_i] : t_r8[basic_timing_i[3:2]];
        end else begin
            idx = m_tsel[2 + m_drv] ? 0 : 1;
            byt = rd ? m_brd[idx] : m_bwr[idx];
            s = 1;
            c = byt[7:4] + 1;
            r = byt[3:0] + 2;
        end
        @(posedge sys_clk_i);
        cycle_req_i <= 1'b1;
        cycle_read_i <= rd;
        cycle_wide_i <= w;
        @(posedge sys_clk_i);
        cycle_req_i <= 1'b0;
        for (k = 1; k < 64 && dn == 0; k++) begin
            @(posedge sys_clk_i);
            if (k == 2) cycle_req_i <= 1'b1;
            if (k == 3) cycle_req_i <= 1'b0;
            #1;
            sb = rd ? rd_n : wr_n;
            if ((rd ? wr_n : rd_n) !== 1'b1) oth++;
            if (sb === 1'b0 && f == 0) f = k;
            if (sb === 1'b0) l = k;
            if (done === 1'b1) dn = k;
        end
        if (dn == 0) begin
            mismatches++;
            $display("unexpected at %0t: cycle never ended", $time);
            wrap_up();
        end
        check(f == s, "setup count");
        check(l == s + c - 1, "command count");
        check(dn == s + c + r, "recovery count");
        check(pw == c && ov == 0 && oth == 0, "drive side pulse");
        check(pc == pc0 + 1, "drive pulse count");
        @(posedge sys_clk_i);
        #1;
        check(busy === 1'b0, "request taken while busy");
    endtask

    initial begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check(tsel_o === 8'h00 && open_o === 1'b0, "reset state");
        check(rd_n === 1'b1 && wr_n === 1'b1, "reset strobes");
        check(busy === 1'b0 && done === 1'b0, "reset busy");
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk_i);
            basic_timing_i <= 4'(i);
            #1;
            run_cycle(1'($random(seed)), 1'b1);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            basic_timing_i <= {2'(i), 2'($random(seed))};
            #1;
            run_cycle(1'($random(seed)), 1'b0);
        end
        $display("test basic table done");
        host_write(10'h1f3, 8'h8c);
        host_write(10'h176, 8'h10);
        host_write(10'h1f2, 8'h5a);
        host_write(10'h1f2, 8'h11);
        host_write(10'h1f2, 8'h5a);
        host_write(10'h1f2, 8'h5a);
        for (i = 0; i < 2; i++) begin
            host_write(10'h1f6, 8'(i));
            host_write(10'h1f0, 8'($random(seed)));
            host_write(10'h1f1, 8'($random(seed)));
        end
        @(posedge sys_clk_i);
        basic_timing_i <= 4'h9;
        for (i = 0; i < 8; i++) begin
            host_write(10'h1f3, {i[2], 3'h0, i[1:0], 2'h0});
            for (j = 0; j < 2; j++) begin
                host_write(10'h1f6, {3'h0, j[0], 4'h0});
                run_cycle(1'b1, 1'b1);
                run_cycle(1'b0, 1'b1);
            end
        end
        host_write(10'h1f3, 8'h08);
        host_write(10'h1f7, 8'h00);
        host_write(10'h1f3, 8'h00);
        host_write(10'h1f0, 8'hff);
        host_write(10'h1f6, 8'h10);
        run_cycle(1'b1, 1'b1);
        host_write(10'h1f6, 8'h00);
        run_cycle(1'b1, 1'b1);
        $display("test hidden timing done");
        @(posedge sys_clk_i);
        port_range_sel_i <= 1'b1;
        #1;
        host_write(10'h1f6, 8'h10);
        host_write(10'h176, 8'h10);
        host_write(10'h172, 8'h5a);
        host_write(10'h172, 8'h5a);
        host_write(10'h173, 8'h84);
        host_write(10'h177, 8'h00);
        run_cycle(1'b0, 1'b1);
        host_write(10'h176, 8'h00);
        run_cycle(1'b1, 1'b1);
        $display("test secondary range done");
        // a second reset must drop the hidden state programmed above
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        m_tsel = 0;
        m_drv = 0;
        m_open = 0;
        m_hb = 0;
        m_ucnt = 0;
        m_brd = '{0, 0};
        m_bwr = '{0, 0};
        #1;
        check(tsel_o === 8'h00 && open_o === 1'b0, "reset again");
        check(act_drv === 1'b0 && busy === 1'b0, "drive after reset");
        run_cycle(1'b0, 1'b1);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
